/* File: ieg_bench.sv */
`timescale 1ns/1ns
module ieg_bench
  import ieg_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  ieg_byte_t  sfr_addr = 8'h00;
  ieg_byte_t  sfr_wdata = 8'h00;
  ieg_byte_t  sfr_rdata;
  logic [8:0] ev_cmd = 9'h000;
  logic [8:0] clr_cmd = 9'h000;
  logic [7:0] pc_cmd = 8'h00;
  logic [8:0] src_event;
  logic [8:0] flag_clear;
  logic [8:0] pending_flags;
  logic [8:0] irq_request;
  logic [7:0] port_pin_change;
  logic       idle_wake;
  logic       stop_wake;
  ieg_byte_t  m;
  ieg_byte_t  e;
  ieg_byte_t  adr [4] = '{8'hA8, 8'hA9, 8'h96, 8'hA7};
  ieg_byte_t  wex [4] = '{8'hBF, 8'h07, 8'hFF, 8'h00};
  int         mismatches = 0;
  int         n_checks = 0;
  int         stops = 0;
  int         s0;

  ieg_top ieg_top_inst (.clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .src_event(src_event), .port_pin_change(port_pin_change), .flag_clear(flag_clear),
    .pending_flags(pending_flags), .irq_request(irq_request), .idle_wake(idle_wake),
    .stop_wake(stop_wake));
  ieg_src_model ieg_src_model_inst (.clk_sys(clk_sys), .ev_cmd(ev_cmd), .pc_cmd(pc_cmd),
    .clr_cmd(clr_cmd), .src_event(src_event), .port_pin_change(port_pin_change),
    .flag_clear(flag_clear));

  initial forever #10 clk_sys = ~clk_sys;
  // wake pulses last one cycle, so count them
  always @(posedge clk_sys) if (stop_wake === 1'b1) stops++;

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(ieg_byte_t a, ieg_byte_t d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(ieg_byte_t a, ieg_byte_t exp);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1;
    check("rdata", sfr_rdata, exp);
  endtask
  // one pulse of events, changes and clears, then let flags settle
  task automatic fire(logic [8:0] ev, ieg_byte_t pc, logic [8:0] cl);
    s0 = stops;
    @(posedge clk_sys);
    ev_cmd <= ev;
    pc_cmd <= pc;
    clr_cmd <= cl;
    @(posedge clk_sys);
    ev_cmd <= 9'h000;
    pc_cmd <= 8'h00;
    clr_cmd <= 9'h000;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clk_sys);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (adr[k]) rd(adr[k], 8'h00);
    foreach (adr[k]) begin
      wr(adr[k], 8'hFF);
      rd(adr[k], wex[k]);
    end
    // gate clear: flags still set, nothing requested, pins still wake
    wr(8'hA8, 8'h3F);
    fire(9'h000, 8'h00, 9'h1FF);
    check("clear", pending_flags, 9'h000);
    fire(9'h17F, 8'h00, 9'h000);
    check("flags", pending_flags, 9'h17F);
    check("irq", irq_request, 9'h000);
    check("idle", idle_wake, 1'b0);
    check("stop", stops - s0, 1);
    wr(8'hA8, 8'hBF);
    repeat (2) @(posedge clk_sys);
    #1;
    check("irq", irq_request, 9'h17F);
    check("idle", idle_wake, 1'b1);
    // one enable at a time; only pin and port change slots wake
    for (int i = 0; i < 9; i++) begin
      m = 8'h80 | ((i < 6) ? 8'h01 << i : 8'h00);
      e = (i == 6) ? 8'h01 : (i == 7) ? 8'h02 : (i == 8) ? 8'h04 : 8'h00;
      wr(8'hA8, m);
      wr(8'hA9, e);
      fire(9'h000, 8'h00, 9'h1FF);
      fire(9'h17F, (i == 7) ? 8'h01 : 8'h00, 9'h000);
      check("irq", irq_request, 9'h001 << i);
      check("stop", stops - s0, (i == 0 || i == 2 || i >= 7) ? 1 : 0);
    end
    // change enable off: masked pin silent, unmasked pin wakes
    wr(8'hA9, 8'h00);
    wr(8'h96, 8'h02);
    fire(9'h000, 8'h00, 9'h1FF);
    fire(9'h000, 8'h01, 9'h000);
    check("flags", pending_flags, 9'h000);
    check("stop", stops - s0, 0);
    fire(9'h000, 8'h02, 9'h000);
    check("flags", pending_flags, 9'h080);
    check("irq", irq_request, 9'h000);
    check("stop", stops - s0, 1);
    // event and clear in one cycle: the set wins
    fire(9'h002, 8'h00, 9'h002);
    check("flags", pending_flags, 9'h082);
    // mid-run reset: main enable, flags and requests return to zero
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(8'hA8, 8'h00);
    check("flags", pending_flags, 9'h000);
    check("irq", irq_request, 9'h000);
    final_report();
  end
endmodule

/* File: ieg_consts.svh */
`ifndef IEG_CONSTS_SVH
`define IEG_CONSTS_SVH

// ---------------------------------------------------------------
// special function register addresses
// ---------------------------------------------------------------
`define IEG_ADDR_MAIN        8'hA8
`define IEG_ADDR_EXT         8'hA9
`define IEG_ADDR_WAKE_MASK   8'h96

// ---------------------------------------------------------------
// reset values and writable bits
// ---------------------------------------------------------------
`define IEG_RST_MAIN         8'h00
`define IEG_RST_EXT          8'h00
`define IEG_RST_WAKE_MASK    8'h00
`define IEG_WR_MASK_MAIN     8'hBF
`define IEG_WR_MASK_EXT      8'h07
`define IEG_WR_MASK_WAKE     8'hFF

// ---------------------------------------------------------------
// field positions, main enable register
// ---------------------------------------------------------------
`define IEG_BIT_GLOBAL_GATE  7
`define IEG_BIT_TIMER2_EN    5
`define IEG_BIT_UART_EN      4
`define IEG_BIT_TIMER1_EN    3
`define IEG_BIT_PIN_B_EN     2
`define IEG_BIT_TIMER0_EN    1
`define IEG_BIT_PIN_A_EN     0

// ---------------------------------------------------------------
// field positions, extension enable register
// ---------------------------------------------------------------
`define IEG_BIT_PIN_C_EN     2
`define IEG_BIT_PORT_CHG_EN  1
`define IEG_BIT_TIMER3_EN    0

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define IEG_NUM_SRC          9
`define IEG_PORT_WIDTH       8

`endif

/* File: ieg_flag_bank.sv */
`timescale 1ns/1ns

module ieg_flag_bank #(
  parameter int NUM = 9
) (
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           nrst,
  // set and clear pulses
  input  wire logic [NUM-1:0] flag_set,
  input  wire logic [NUM-1:0] flag_clr,
  // sticky flags
  output logic      [NUM-1:0] flags
);

  logic [NUM-1:0] flags_reg;
  logic [NUM-1:0] flags_next;

  // set beats clear so an event in the clearing cycle survives
  always_comb begin
    flags_next = (flags_reg & ~flag_clr) | flag_set;
  end

  // sticky flag storage
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule

/* File: ieg_pkg.sv */
`include "ieg_consts.svh"

package ieg_pkg;

  // one byte of the special function register space
  typedef logic [7:0] ieg_byte_t;

  // source slots, in the order of the request and flag vectors
  typedef enum {
    IEG_SRC_PIN_A,
    IEG_SRC_TIMER0,
    IEG_SRC_PIN_B,
    IEG_SRC_TIMER1,
    IEG_SRC_UART,
    IEG_SRC_TIMER2,
    IEG_SRC_TIMER3,
    IEG_SRC_PORT_CHG,
    IEG_SRC_PIN_C
  } ieg_src_e;

  // one-hot register select: {wake mask, extension, main}
  typedef logic [2:0] ieg_sel_t;

endpackage

/* File: ieg_src_model.sv */
`timescale 1ns/1ns
// ---
// cpu core and event sources
// ---
module ieg_src_model (
  // clock
  input  wire logic       clk_sys,
  // commands
  input  wire logic [8:0] ev_cmd,
  input  wire logic [7:0] pc_cmd,
  input  wire logic [8:0] clr_cmd,
  // pulses to the block
  output logic      [8:0] src_event,
  output logic      [7:0] port_pin_change,
  output logic      [8:0] flag_clear
);
  // sources fire whatever the enables hold
  always_ff @(posedge clk_sys) begin
    src_event       <= ev_cmd;
    port_pin_change <= pc_cmd;
    flag_clear      <= clr_cmd;
  end
endmodule

/* File: ieg_top.sv */
`timescale 1ns/1ns
`include "ieg_consts.svh"

// Notes on behaviour
// - With the global gate clear no request reaches the cpu, with it set each source follows its enable.
// - Main register bits 5, 4, 3 and 1 enable timer2, uart, timer1 and timer0 requests.
// - Each external pin enable gates both that pin's request and its stop-mode wake-up.
// - An enabled external pin wakes the cpu from stop mode whatever the global gate says.
// - The port change enable gates only the change request and never the port wake-up.
// - Extension register bit 0 enables the timer3 request under the global gate.
// - Every event sets its flag even while its enable is clear.
// - Any enabled request wakes from idle, but only pin events wake from stop.
// - An eight-bit per-pin mask chooses which port pins may raise a change or wake-up.

module ieg_top
  import ieg_pkg::*;
#(
  parameter int NUM_SRC = `IEG_NUM_SRC,
  parameter int PORT_W  = `IEG_PORT_WIDTH
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  // special function register access from the cpu core
  input  wire logic [7:0]         sfr_addr,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  input  wire logic [7:0]         sfr_wdata,
  output logic      [7:0]         sfr_rdata,
  // event pulses from the interrupt sources
  input  wire logic [NUM_SRC-1:0] src_event,
  input  wire logic [PORT_W-1:0]  port_pin_change,
  // flag clear pulses from the cpu on vector entry
  input  wire logic [NUM_SRC-1:0] flag_clear,
  // flags, gated requests and wake-up
  output logic      [NUM_SRC-1:0] pending_flags,
  output logic      [NUM_SRC-1:0] irq_request,
  output logic                    idle_wake,
  output logic                    stop_wake
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------

  // one-hot select, shared by write and read paths
  function automatic ieg_sel_t ieg_decode(input logic [7:0] addr);
    ieg_sel_t sel;
    sel    = '0;
    sel[0] = (addr == `IEG_ADDR_MAIN);
    sel[1] = (addr == `IEG_ADDR_EXT);
    sel[2] = (addr == `IEG_ADDR_WAKE_MASK);
    return sel;
  endfunction

  ieg_sel_t wr_sel;
  ieg_sel_t rd_sel;

  assign wr_sel = sfr_wr ? ieg_decode(sfr_addr) : '0;
  assign rd_sel = sfr_rd ? ieg_decode(sfr_addr) : '0;

  // ---------------------------------------------------------------
  // enable registers
  // ---------------------------------------------------------------

  ieg_byte_t main_en_reg;
  ieg_byte_t ext_en_reg;
  ieg_byte_t wake_mask_reg;

  // main enable register, bit 6 is reserved and stays zero
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      main_en_reg <= `IEG_RST_MAIN;
    end else if (wr_sel[0]) begin
      main_en_reg <= sfr_wdata & `IEG_WR_MASK_MAIN;
    end
  end

  // extension enable register, upper five bits reserved
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ext_en_reg <= `IEG_RST_EXT;
    end else if (wr_sel[1]) begin
      ext_en_reg <= sfr_wdata & `IEG_WR_MASK_EXT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wake_mask_reg <= `IEG_RST_WAKE_MASK;
    end else if (wr_sel[2]) begin
      wake_mask_reg <= sfr_wdata & `IEG_WR_MASK_WAKE;
    end
  end

  // ---------------------------------------------------------------
  // named enable fields
  // ---------------------------------------------------------------

  logic global_irq_gate;
  logic timer2_irq_enable;
  logic uart_irq_enable;
  logic timer1_irq_enable;
  logic timer0_irq_enable;
  logic pin_a_irq_wake_enable;
  logic pin_b_irq_wake_enable;
  logic pin_c_irq_wake_enable;
  logic port_change_irq_enable;
  logic timer3_irq_enable;

  assign global_irq_gate        = main_en_reg[`IEG_BIT_GLOBAL_GATE];
  assign timer2_irq_enable      = main_en_reg[`IEG_BIT_TIMER2_EN];
  assign uart_irq_enable        = main_en_reg[`IEG_BIT_UART_EN];
  assign timer1_irq_enable      = main_en_reg[`IEG_BIT_TIMER1_EN];
  assign pin_b_irq_wake_enable  = main_en_reg[`IEG_BIT_PIN_B_EN];
  assign timer0_irq_enable      = main_en_reg[`IEG_BIT_TIMER0_EN];
  assign pin_a_irq_wake_enable  = main_en_reg[`IEG_BIT_PIN_A_EN];
  assign pin_c_irq_wake_enable  = ext_en_reg[`IEG_BIT_PIN_C_EN];
  assign port_change_irq_enable = ext_en_reg[`IEG_BIT_PORT_CHG_EN];
  assign timer3_irq_enable      = ext_en_reg[`IEG_BIT_TIMER3_EN];

  // per-source enable vector, slot order follows ieg_src_e
  logic [NUM_SRC-1:0] src_enable;

  always_comb begin
    src_enable                   = '0;
    src_enable[IEG_SRC_PIN_A]    = pin_a_irq_wake_enable;
    src_enable[IEG_SRC_TIMER0]   = timer0_irq_enable;
    src_enable[IEG_SRC_PIN_B]    = pin_b_irq_wake_enable;
    src_enable[IEG_SRC_TIMER1]   = timer1_irq_enable;
    src_enable[IEG_SRC_UART]     = uart_irq_enable;
    src_enable[IEG_SRC_TIMER2]   = timer2_irq_enable;
    src_enable[IEG_SRC_TIMER3]   = timer3_irq_enable;
    src_enable[IEG_SRC_PORT_CHG] = port_change_irq_enable;
    src_enable[IEG_SRC_PIN_C]    = pin_c_irq_wake_enable;
  end

  // ---------------------------------------------------------------
  // event capture
  // ---------------------------------------------------------------

  // only unmasked pins count as a change
  logic port_change_hit;

  assign port_change_hit = |(port_pin_change & wake_mask_reg[PORT_W-1:0]);

  logic [NUM_SRC-1:0] flag_set;

  always_comb begin
    flag_set                   = src_event;
    flag_set[IEG_SRC_PORT_CHG] = src_event[IEG_SRC_PORT_CHG] | port_change_hit;
  end

  logic [NUM_SRC-1:0] flags;

  ieg_flag_bank #(
    .NUM      (NUM_SRC)
  ) ieg_flag_bank_inst (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .flag_set (flag_set),
    .flag_clr (flag_clear),
    .flags    (flags)
  );

  // ---------------------------------------------------------------
  // request gating
  // ---------------------------------------------------------------

  logic [NUM_SRC-1:0] gated_req;

  assign gated_req = flags & src_enable & {NUM_SRC{global_irq_gate}};

  logic [NUM_SRC-1:0] irq_request_reg;
  logic [NUM_SRC-1:0] pending_flags_reg;

  // requests lag the flags by one edge to keep outputs on flops
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_request_reg   <= '0;
      pending_flags_reg <= '0;
    end else begin
      irq_request_reg   <= gated_req;
      pending_flags_reg <= flags;
    end
  end

  // ---------------------------------------------------------------
  // wake-up
  // ---------------------------------------------------------------

  logic idle_wake_reg;
  logic stop_wake_reg;
  logic stop_wake_next;

  // idle wake from any serviceable request
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      idle_wake_reg <= 1'b0;
    end else begin
      idle_wake_reg <= |gated_req;
    end
  end

  // pin wake ignores the global gate
  // port wake follows the pin mask only, not its enable
  always_comb begin
    stop_wake_next = (src_event[IEG_SRC_PIN_A] & pin_a_irq_wake_enable)
                   | (src_event[IEG_SRC_PIN_B] & pin_b_irq_wake_enable)
                   | (src_event[IEG_SRC_PIN_C] & pin_c_irq_wake_enable)
                   | port_change_hit;
  end

  // timers and uart never reach the stop wake path
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stop_wake_reg <= 1'b0;
    end else begin
      stop_wake_reg <= stop_wake_next;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  ieg_byte_t rdata_reg;

  // reads give zero outside a read or at an unmapped address
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else begin
      case (rd_sel)
        3'b001:  rdata_reg <= main_en_reg;
        3'b010:  rdata_reg <= ext_en_reg;
        3'b100:  rdata_reg <= wake_mask_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  assign sfr_rdata     = rdata_reg;
  assign pending_flags = pending_flags_reg;
  assign irq_request   = irq_request_reg;
  assign idle_wake     = idle_wake_reg;
  assign stop_wake     = stop_wake_reg;

endmodule

/* File: ieg_top_asserts.sv */
`timescale 1ns/1ns
`include "ieg_consts.svh"
// ---
// gating checks
// ---
module ieg_top_asserts #(
  parameter int NUM_SRC = 9,
  parameter int PORT_W  = 8
) (
  // register bus
  input wire logic               clk_sys,
  input wire logic               nrst,
  input wire logic [7:0]         sfr_addr,
  input wire logic               sfr_wr,
  input wire logic               sfr_rd,
  input wire logic [7:0]         sfr_wdata,
  input wire logic [7:0]         sfr_rdata,
  // events and outputs
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [PORT_W-1:0]  port_pin_change,
  input wire logic [NUM_SRC-1:0] flag_clear,
  input wire logic [NUM_SRC-1:0] pending_flags,
  input wire logic [NUM_SRC-1:0] irq_request,
  input wire logic               idle_wake,
  input wire logic               stop_wake
);
  logic [7:0] m_reg;
  logic [7:0] e_reg;
  logic [7:0] w_reg;
  logic [8:0] en;
  logic [7:0] rd_exp;
  logic       wk;
  // shadow enables, so gating is judged against what was written
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      m_reg <= 8'h00;
      e_reg <= 8'h00;
      w_reg <= 8'h00;
    end else if (sfr_wr) begin
      if (sfr_addr == `IEG_ADDR_MAIN) m_reg <= sfr_wdata & `IEG_WR_MASK_MAIN;
      if (sfr_addr == `IEG_ADDR_EXT) e_reg <= sfr_wdata & `IEG_WR_MASK_EXT;
      if (sfr_addr == `IEG_ADDR_WAKE_MASK) w_reg <= sfr_wdata;
    end
  end
  // slot order follows the request vector
  assign en = {e_reg[2:0], m_reg[5:0]} & {9{m_reg[7]}};
  assign wk = (src_event[0] & m_reg[0]) | (src_event[2] & m_reg[2])
            | (src_event[8] & e_reg[2]) | (|(port_pin_change & w_reg));
  assign rd_exp = (sfr_addr == `IEG_ADDR_MAIN) ? m_reg :
                  (sfr_addr == `IEG_ADDR_EXT) ? e_reg :
                  (sfr_addr == `IEG_ADDR_WAKE_MASK) ? w_reg : 8'h00;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_GATE_OFF: assert property (!$past(m_reg[7]) |-> irq_request == '0)
    else $error("request with gate clear");
  AST_IRQ_EXACT: assert property (irq_request == (pending_flags & $past(en)))
    else $error("request differs from flags and enables");
  AST_FLAG_SET: assert property (src_event != '0 |-> ##2
    ((pending_flags & $past(src_event, 2)) == $past(src_event, 2)))
    else $error("event flag not set");
  AST_PORT_FLAG: assert property ((port_pin_change & w_reg) != 0 |-> ##2 pending_flags[7])
    else $error("port change flag not set");
  AST_IDLE: assert property (idle_wake == (irq_request != '0))
    else $error("idle wake mismatch");
  AST_STOP_PIN: assert property (src_event[8] && e_reg[2] |=> stop_wake)
    else $error("pin c did not wake");
  AST_STOP_EXACT: assert property (stop_wake == $past(wk))
    else $error("stop wake mismatch");
  AST_RD_DATA: assert property (sfr_rd |=> sfr_rdata == $past(rd_exp))
    else $error("read data mismatch");
  AST_RD_IDLE: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data outside read");
  COV_IRQ: cover property (irq_request != '0);
  COV_STOP: cover property (stop_wake);
  COV_RD_MASK: cover property (sfr_rd && sfr_addr == 8'h96);
endmodule

bind ieg_top ieg_top_asserts #(.NUM_SRC(NUM_SRC), .PORT_W(PORT_W)) ieg_top_asserts_inst (
  .clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .src_event(src_event), .port_pin_change(port_pin_change),
  .flag_clear(flag_clear), .pending_flags(pending_flags),
  .irq_request(irq_request), .idle_wake(idle_wake), .stop_wake(stop_wake));
